// [rtl/uart_line_control.v]
// Line control of an asynchronous serial port with format, break, divisor access and loopback
//
// What this block does
// - With divisor access set, divisor offsets reach the low and high divisor latches.
// - Divisor access, parity, stop and length fields are written only while not busy.
// - Break without loopback holds the serial output low until break is cleared.
// - Break in infrared mode without loopback pulses the infrared output continuously while break stays set.
// - Break in loopback feeds a break to the own receiver; infrared output held low in infrared mode.
// - Parity on adds a parity bit on transmit and checks it on receive.
// - Parity even select gives an even count of ones, otherwise odd.
// - One stop bit, or 1.5 at five data bits, else two when selected.
// - The receiver checks only the first stop bit for framing.
// - Length field 00..11 selects 5, 6, 7 or 8 data bits.
// - Loopback without infrared holds serial output high and loops transmit data inside.
`timescale 1ns/1ns
`include "uart_line_control_defines.vh"
module uart_line_control #(
    parameter ADDR_W = 32,
    parameter DATA_W = 16
)(
    input  wire              CORE_CLK,
    input  wire              RESETN,
    input  wire [ADDR_W-1:0] ADDR,
    input  wire [DATA_W-1:0] WDATA,
    input  wire              WR,
    input  wire              RD,
    output reg  [DATA_W-1:0] RDATA,
    input  wire              PORT_BUSY,
    input  wire              LOOPBACK_ON,
    input  wire              IR_MODE_ON,
    input  wire              SER_IN,
    output reg               SER_OUT,
    output reg               IR_OUT_N,
    output reg               DIV_ACCESS,
    output reg               RX_READY
);
    reg        rst_meta_r;
    reg        rst_sync_r;
    wire       rst_n = rst_sync_r;

    reg        div_access_r;
    reg        break_r;
    reg        even_r;
    reg        parity_r;
    reg        stop_r;
    reg  [1:0] len_r;
    reg  [7:0] div_low_r;
    reg  [7:0] div_high_r;
    reg [15:0] baud_cnt_r;
    reg        tick_r;

    reg        sin_s1_r;
    reg        sin_s2_r;
    reg        sin_s3_r;
    reg        sin_filt_r;

    reg        rx_ready_r;
    reg        rx_ready_nxt;
    reg        perr_r;
    reg        perr_nxt;
    reg        ferr_r;
    reg        ferr_nxt;
    reg  [7:0] rx_hold_r;

    reg        ser_out_nxt;
    reg        ir_out_n_nxt;
    reg        rx_line;
    reg [DATA_W-1:0] rdata_nxt;

    wire       tx_busy;
    wire       tx_line;
    wire [3:0] tx_phase;
    wire [7:0] rx_data;
    wire       rx_valid;
    wire       rx_perr;
    wire       rx_ferr;

    wire [15:0] divisor = {div_high_r, div_low_r};
    wire [7:0]  lfc_val = {div_access_r, break_r, 1'b0, even_r, parity_r, stop_r, len_r};

    wire wr_lfc    = WR && (ADDR == `LFC_ADDR);
    wire wr_div_lo = WR && div_access_r && (ADDR == `DIV_LOW_ADDR);
    wire wr_div_hi = WR && div_access_r && (ADDR == `DIV_HIGH_ADDR);
    wire wr_tx     = WR && (ADDR == `TX_CHAR_ADDR);
    wire rd_status = RD && (ADDR == `PORT_STATUS_ADDR);

    // Reset release through two stages, assertion stays asynchronous
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Line format fields; break stays writable while busy so a break can be forced mid-character
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_access_r <= 1'b0;
            break_r      <= 1'b0;
            even_r       <= 1'b0;
            parity_r     <= 1'b0;
            stop_r       <= 1'b0;
            len_r        <= 2'h0;
        end else if (wr_lfc) begin
            break_r <= WDATA[`LFC_BREAK_BIT];
            if (!PORT_BUSY) begin
                div_access_r <= WDATA[`LFC_DIV_ACCESS_BIT];
                even_r       <= WDATA[`LFC_EVEN_BIT];
                parity_r     <= WDATA[`LFC_PARITY_BIT];
                stop_r       <= WDATA[`LFC_STOP_BIT];
                len_r        <= WDATA[`LFC_LEN_HI:`LFC_LEN_LO];
            end
        end
    end

    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_low_r  <= `DIV_RESET;
            div_high_r <= `DIV_RESET;
        end else begin
            if (wr_div_lo)
                div_low_r <= WDATA[7:0];
            if (wr_div_hi)
                div_high_r <= WDATA[7:0];
        end
    end

    // Oversampling tick at CORE_CLK / divisor; a zero divisor stops the port
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            baud_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end else if (divisor == 16'h0000) begin
            baud_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end else if (baud_cnt_r >= divisor - 16'h0001) begin
            baud_cnt_r <= 16'h0000;
            tick_r     <= 1'b1;
        end else begin
            baud_cnt_r <= baud_cnt_r + 16'h0001;
            tick_r     <= 1'b0;
        end
    end

    // Pin synchroniser; the filtered level moves only when stages two and three agree
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sin_s1_r   <= 1'b1;
            sin_s2_r   <= 1'b1;
            sin_s3_r   <= 1'b1;
            sin_filt_r <= 1'b1;
        end else begin
            sin_s1_r <= SER_IN;
            sin_s2_r <= sin_s1_r;
            sin_s3_r <= sin_s2_r;
            if (sin_s2_r == sin_s3_r)
                sin_filt_r <= sin_s3_r;
        end
    end

    uart_char_tx u_tx (
        .clk         (CORE_CLK),
        .rst_n       (rst_n),
        .tick        (tick_r),
        .start       (wr_tx),
        .data        (WDATA[7:0]),
        .len_sel     (len_r),
        .parity_on   (parity_r),
        .parity_even (even_r),
        .stop_long   (stop_r),
        .busy_r      (tx_busy),
        .line_r      (tx_line),
        .phase       (tx_phase)
    );

    uart_char_rx u_rx (
        .clk         (CORE_CLK),
        .rst_n       (rst_n),
        .tick        (tick_r),
        .line        (rx_line),
        .len_sel     (len_r),
        .parity_on   (parity_r),
        .parity_even (even_r),
        .data_r      (rx_data),
        .valid_r     (rx_valid),
        .perr_r      (rx_perr),
        .ferr_r      (rx_ferr)
    );

    // Line routing for normal, break, loopback and infrared cases
    always @* begin
        rx_line      = sin_filt_r;
        ser_out_nxt  = tx_line;
        ir_out_n_nxt = 1'b1;
        if (LOOPBACK_ON) begin
            rx_line     = break_r ? 1'b0 : tx_line;
            ser_out_nxt = 1'b1;
        end else if (break_r) begin
            ser_out_nxt = 1'b0;
        end
        if (IR_MODE_ON) begin
            if (LOOPBACK_ON)
                ir_out_n_nxt = 1'b0;
            else if (break_r || !tx_line)
                ir_out_n_nxt = ~(tx_phase < `IR_PULSE_TICKS);
        end
    end

    // Receive flags are sticky; a new event in the clearing read cycle wins
    always @* begin
        rx_ready_nxt = rx_valid | (rx_ready_r & ~rd_status);
        perr_nxt     = (rx_valid & rx_perr) | (perr_r & ~rd_status);
        ferr_nxt     = (rx_valid & rx_ferr) | (ferr_r & ~rd_status);
    end

    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_ready_r <= 1'b0;
            perr_r     <= 1'b0;
            ferr_r     <= 1'b0;
            rx_hold_r  <= 8'h00;
        end else begin
            rx_ready_r <= rx_ready_nxt;
            perr_r     <= perr_nxt;
            ferr_r     <= ferr_nxt;
            if (rx_valid)
                rx_hold_r <= rx_data;
        end
    end

    // Read mux; divisor offsets answer zero while divisor access is clear
    always @* begin
        rdata_nxt = {DATA_W{1'b0}};
        if (RD) begin
            if (ADDR == `LFC_ADDR)
                rdata_nxt[7:0] = lfc_val;
            else if (ADDR == `DIV_LOW_ADDR && div_access_r)
                rdata_nxt[7:0] = div_low_r;
            else if (ADDR == `DIV_HIGH_ADDR && div_access_r)
                rdata_nxt[7:0] = div_high_r;
            else if (ADDR == `PORT_STATUS_ADDR) begin
                rdata_nxt[7:0]                = rx_hold_r;
                rdata_nxt[`STAT_RX_READY_BIT] = rx_ready_r;
                rdata_nxt[`STAT_PERR_BIT]     = perr_r;
                rdata_nxt[`STAT_FERR_BIT]     = ferr_r;
                rdata_nxt[`STAT_TX_BUSY_BIT]  = tx_busy;
            end
        end
    end

    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA      <= {DATA_W{1'b0}};
            SER_OUT    <= 1'b1;
            IR_OUT_N   <= 1'b1;
            DIV_ACCESS <= 1'b0;
            RX_READY   <= 1'b0;
        end else begin
            RDATA      <= rdata_nxt;
            SER_OUT    <= ser_out_nxt;
            IR_OUT_N   <= ir_out_n_nxt;
            DIV_ACCESS <= div_access_r;
            RX_READY   <= rx_ready_r;
        end
    end
endmodule

// [common/uart_line_control_defines.vh]
// Shared offsets, field positions, reset values and timing counts for the line control block
`ifndef UART_LINE_CONTROL_DEFINES_VH
`define UART_LINE_CONTROL_DEFINES_VH

`define LFC_ADDR          32'h5000100C
`define DIV_LOW_ADDR      32'h50001000
`define DIV_HIGH_ADDR     32'h50001004
`define PORT_STATUS_ADDR  32'h50001050
`define TX_CHAR_ADDR      32'h50001054

`define LFC_DIV_ACCESS_BIT  7
`define LFC_BREAK_BIT       6
`define LFC_EVEN_BIT        4
`define LFC_PARITY_BIT      3
`define LFC_STOP_BIT        2
`define LFC_LEN_HI          1
`define LFC_LEN_LO          0

`define LFC_RESET           8'h00
`define DIV_RESET           8'h00

`define STAT_RX_READY_BIT   8
`define STAT_PERR_BIT       9
`define STAT_FERR_BIT       10
`define STAT_TX_BUSY_BIT    11

`define TICKS_PER_BIT       4'hF
`define STOP_TICKS_ONE      6'h10
`define STOP_TICKS_HALF     6'h18
`define STOP_TICKS_TWO      6'h20
`define RX_MID_START        4'h7
`define IR_PULSE_TICKS      4'h3

`endif

// [rtl/uart_char_tx.v]
// Character serializer: start, 5 to 8 data bits, optional parity, 1, 1.5 or 2 stop bits
`timescale 1ns/1ns
`include "uart_line_control_defines.vh"
module uart_char_tx (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       tick,
    input  wire       start,
    input  wire [7:0] data,
    input  wire [1:0] len_sel,
    input  wire       parity_on,
    input  wire       parity_even,
    input  wire       stop_long,
    output reg        busy_r,
    output reg        line_r,
    output wire [3:0] phase
);
    localparam S_IDLE  = 5'b00001;
    localparam S_START = 5'b00010;
    localparam S_DATA  = 5'b00100;
    localparam S_PAR   = 5'b01000;
    localparam S_STOP  = 5'b10000;

    reg [4:0] state_r;
    reg [3:0] phase_r;
    reg [7:0] shift_r;
    reg [2:0] bit_r;
    reg [5:0] stop_r;
    reg       par_r;
    reg       pend_r;

    wire       edge_w   = tick & (phase_r == `TICKS_PER_BIT);
    wire [2:0] last_w   = {1'b0, len_sel} + 3'h4;
    wire [7:0] mask_w   = 8'hFF >> (3'h3 - {1'b0, len_sel});
    wire [5:0] stop_len = !stop_long ? `STOP_TICKS_ONE :
                          (len_sel == 2'h0) ? `STOP_TICKS_HALF : `STOP_TICKS_TWO;

    assign phase = phase_r;

    // Phase runs free so a break on an idle line still gives an IR pulse rhythm
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            phase_r <= 4'h0;
            shift_r <= 8'h00;
            bit_r   <= 3'h0;
            stop_r  <= 6'h00;
            par_r   <= 1'b0;
            pend_r  <= 1'b0;
            busy_r  <= 1'b0;
            line_r  <= 1'b1;
        end else begin
            if (tick)
                phase_r <= phase_r + 4'h1;
            if (start && !busy_r) begin
                busy_r  <= 1'b1;
                pend_r  <= 1'b1;
                shift_r <= data & mask_w;
                par_r   <= (^(data & mask_w)) ^ ~parity_even;
            end
            case (state_r)
                S_IDLE: begin
                    if (edge_w && pend_r) begin
                        pend_r  <= 1'b0;
                        line_r  <= 1'b0;
                        bit_r   <= 3'h0;
                        state_r <= S_START;
                    end
                end
                S_START: begin
                    if (edge_w) begin
                        line_r  <= shift_r[0];
                        state_r <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (edge_w) begin
                        if (bit_r == last_w) begin
                            stop_r  <= 6'h00;
                            line_r  <= parity_on ? par_r : 1'b1;
                            state_r <= parity_on ? S_PAR : S_STOP;
                        end else begin
                            bit_r   <= bit_r + 3'h1;
                            shift_r <= {1'b0, shift_r[7:1]};
                            line_r  <= shift_r[1];
                        end
                    end
                end
                S_PAR: begin
                    if (edge_w) begin
                        line_r  <= 1'b1;
                        state_r <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (tick) begin
                        stop_r <= stop_r + 6'h01;
                        if (stop_r == stop_len - 6'h01) begin
                            busy_r  <= 1'b0;
                            state_r <= S_IDLE;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule

// [rtl/uart_char_rx.v]
// Character deserializer with parity and first-stop-bit framing check
`timescale 1ns/1ns
`include "uart_line_control_defines.vh"
module uart_char_rx (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       tick,
    input  wire       line,
    input  wire [1:0] len_sel,
    input  wire       parity_on,
    input  wire       parity_even,
    output reg  [7:0] data_r,
    output reg        valid_r,
    output reg        perr_r,
    output reg        ferr_r
);
    localparam S_IDLE  = 5'b00001;
    localparam S_START = 5'b00010;
    localparam S_DATA  = 5'b00100;
    localparam S_PAR   = 5'b01000;
    localparam S_STOP  = 5'b10000;

    reg [4:0] state_r;
    reg [3:0] cnt_r;
    reg [2:0] bit_r;

    wire       mid_w  = tick & (cnt_r == `TICKS_PER_BIT);
    wire [2:0] last_w = {1'b0, len_sel} + 3'h4;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            cnt_r   <= 4'h0;
            bit_r   <= 3'h0;
            data_r  <= 8'h00;
            valid_r <= 1'b0;
            perr_r  <= 1'b0;
            ferr_r  <= 1'b0;
        end else begin
            valid_r <= 1'b0;
            if (tick)
                cnt_r <= cnt_r + 4'h1;
            case (state_r)
                S_IDLE: begin
                    if (tick && !line) begin
                        cnt_r   <= 4'h0;
                        state_r <= S_START;
                    end
                end
                S_START: begin
                    // Re-check at mid bit so a glitch is not taken as a start
                    if (tick && cnt_r == `RX_MID_START) begin
                        cnt_r   <= 4'h0;
                        bit_r   <= 3'h0;
                        data_r  <= 8'h00;
                        perr_r  <= 1'b0;
                        state_r <= line ? S_IDLE : S_DATA;
                    end
                end
                S_DATA: begin
                    if (mid_w) begin
                        data_r[bit_r] <= line;
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == last_w)
                            state_r <= parity_on ? S_PAR : S_STOP;
                    end
                end
                S_PAR: begin
                    if (mid_w) begin
                        perr_r  <= (^data_r ^ line) ^ ~parity_even;
                        state_r <= S_STOP;
                    end
                end
                S_STOP: begin
                    // Only the first stop bit is looked at; later ones pass as idle
                    if (mid_w) begin
                        ferr_r  <= ~line;
                        valid_r <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule

// [verification/uart_line_control_chk.sv]
// Port assertions for the line control block
`timescale 1ns/1ns
`include "uart_line_control_defines.vh"
module uart_line_control_chk #(
    parameter ADDR_W = 32,
    parameter DATA_W = 16
)(
    input wire              CORE_CLK,
    input wire              RESETN,
    input wire [ADDR_W-1:0] ADDR,
    input wire [DATA_W-1:0] WDATA,
    input wire              WR,
    input wire              RD,
    input wire [DATA_W-1:0] RDATA,
    input wire              PORT_BUSY,
    input wire              LOOPBACK_ON,
    input wire              IR_MODE_ON,
    input wire              SER_IN,
    input wire              SER_OUT,
    input wire              IR_OUT_N,
    input wire              DIV_ACCESS,
    input wire              RX_READY
);
    reg  [7:0] lfc_m;
    reg  [7:0] dlo_m;
    reg  [3:0] low_r;
    reg  [4:0] hi_r;
    wire       lfc_wr = WR && ADDR == `LFC_ADDR;
    // Pulse timing holds only with a divisor of one
    wire       ir_brk = IR_MODE_ON && !LOOPBACK_ON && lfc_m[6] && dlo_m == 8'h01;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            lfc_m <= 8'h00;
            dlo_m <= 8'h00;
            low_r <= 4'h0;
            hi_r  <= 5'h00;
        end else begin
            // High stretch counted only while break lasts, so leaving infrared mode is no miss
            hi_r  <= (IR_OUT_N && ir_brk) ? hi_r + 5'h01 : 5'h00;
            low_r <= IR_OUT_N ? 4'h0 : low_r + 4'h1;
            if (lfc_wr)
                lfc_m <= PORT_BUSY ? {lfc_m[7], WDATA[6], lfc_m[5:0]} : WDATA[7:0] & 8'hDF;
            else if (WR && ADDR == `DIV_LOW_ADDR && lfc_m[7])
                dlo_m <= WDATA[7:0];
        end
    end
    format_readback_a: assert property (RD && ADDR == `LFC_ADDR |=> RDATA == {8'h00, $past(lfc_m)})
        else $error("line control readback wrong");
    div_copy_a: assert property (DIV_ACCESS == $past(lfc_m[7]))
        else $error("divisor access copy wrong");
    div_hidden_a: assert property (RD && ADDR == `DIV_LOW_ADDR && !lfc_m[7] |=> RDATA == 16'h0000)
        else $error("divisor visible without access");
    busy_hold_a: assert property (lfc_wr && PORT_BUSY |=> ##1 $stable(DIV_ACCESS))
        else $error("format changed while busy");
    break_low_a: assert property (lfc_m[6] && !LOOPBACK_ON && $past(RESETN, 3) |=> !SER_OUT)
        else $error("break not driven low");
    loop_high_a: assert property (LOOPBACK_ON && !IR_MODE_ON && $past(RESETN, 3) |=> SER_OUT)
        else $error("loopback output not high");
    loop_ir_low_a: assert property (LOOPBACK_ON && IR_MODE_ON && $past(RESETN, 3) |=> !IR_OUT_N)
        else $error("infrared output not low in loopback");
    ir_pulse_due_a: assert property (hi_r <= 5'h10)
        else $error("no infrared break pulse");
    ir_pulse_len_a: assert property (ir_brk && $past(ir_brk, 4) && $rose(IR_OUT_N) |-> low_r == 4'h3)
        else $error("infrared pulse width wrong");
    cover property (lfc_m[6] && !LOOPBACK_ON ##1 !SER_OUT);
    cover property (ir_brk && $fell(IR_OUT_N));
    cover property (lfc_wr && PORT_BUSY);
endmodule
bind uart_line_control uart_line_control_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PORT_BUSY(PORT_BUSY), .LOOPBACK_ON(LOOPBACK_ON), .IR_MODE_ON(IR_MODE_ON),
    .SER_IN(SER_IN), .SER_OUT(SER_OUT), .IR_OUT_N(IR_OUT_N), .DIV_ACCESS(DIV_ACCESS),
    .RX_READY(RX_READY)
);

// [verification/remote_serial_model.sv]
// Remote serial device: frame sender and line sampler
`timescale 1ns/1ns
module remote_serial_model #(
    parameter BIT = 16
)(
    input  wire clk,
    input  wire line_in,
    output reg  line_out
);
    integer i;
    initial line_out = 1'b1;
    task hold(input b, input integer n);
        begin
            line_out <= b;
            repeat (n) @(posedge clk);
        end
    endtask
    // flt: 1 parity flipped, 2 first stop low, 3 no idle after the stop bit
    task send(input [7:0] d, input [3:0] n, input pon, input pev, input [1:0] flt);
        begin
            @(posedge clk);
            hold(1'b0, BIT);
            for (i = 0; i < n; i = i + 1)
                hold(d[i], BIT);
            if (pon)
                hold(^(d & ~(8'hFF << n)) ^ !pev ^ (flt == 2'd1), BIT);
            hold(flt != 2'd2, BIT);
            hold(1'b1, flt == 2'd3 ? 0 : 3 * BIT);
        end
    endtask
    task grab(output [11:0] bits);
        integer k;
        begin
            k = 0;
            while (line_in !== 1'b0 && k < 40 * BIT) begin
                @(posedge clk);
                k = k + 1;
            end
            repeat (BIT / 2) @(posedge clk);
            for (k = 0; k < 12; k = k + 1) begin
                bits[k] = line_in;
                repeat (BIT) @(posedge clk);
            end
        end
    endtask
endmodule

// [verification/uart_line_control_tb_top.sv]
// Testbench for the line control block
`timescale 1ns/1ns
`include "uart_line_control_defines.vh"
module uart_line_control_tb_top;
    reg         core_clk;
    reg         resetn;
    reg  [31:0] addr;
    reg  [15:0] wdata;
    reg         wr;
    reg         rd;
    reg         busy;
    reg         loop_on;
    reg         ir_on;
    wire [15:0] rdata;
    wire        ser_in;
    wire        ser_out;
    wire        ir_out_n;
    wire        div_acc;
    wire        rx_rdy;
    integer     error_cnt;
    integer     tests_run;
    integer     cyc = 0;
    integer     t_fall;
    integer     t1;
    integer     i;
    integer     k;
    integer     n;
    integer     exp;
    reg  [15:0] d;
    reg  [11:0] bits;
    reg  [11:0] ebits;
    reg  [7:0]  lfc;
    reg  [7:0]  ch;
    reg  [1:0]  flt;
    reg  [3:0]  nb;
    reg  [23:0] rows [0:5];
    uart_line_control dut_u (
        .CORE_CLK(core_clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .PORT_BUSY(busy), .LOOPBACK_ON(loop_on), .IR_MODE_ON(ir_on),
        .SER_IN(ser_in), .SER_OUT(ser_out), .IR_OUT_N(ir_out_n), .DIV_ACCESS(div_acc),
        .RX_READY(rx_rdy)
    );
    remote_serial_model rem_u (.clk(core_clk), .line_in(ser_out), .line_out(ser_in));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    // First fall only: zero data bits fall as well
    always @(negedge ser_out) if (t_fall < 0) t_fall = cyc;
    task check(input [15:0] seen, input [15:0] want);
        begin
            tests_run = tests_run + 1;
            if (seen !== want) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t seen %h want %h", $time, seen, want);
            end
        end
    endtask
    task wrt(input [31:0] a, input [15:0] v);
        begin
            @(posedge core_clk);
            addr <= a;
            wdata <= v;
            wr <= 1'b1;
            @(posedge core_clk);
            wr <= 1'b0;
        end
    endtask
    task rdr(input [31:0] a, output [15:0] v);
        begin
            @(posedge core_clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge core_clk);
            rd <= 1'b0;
            #1 v = rdata;
        end
    endtask
    task conclude;
        begin
            $display("compares %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        #300000;
        error_cnt = error_cnt + 1;
        conclude;
    end
    initial begin
        {resetn, wr, rd, busy, loop_on, ir_on} = 6'h00;
        addr = 32'h0;
        wdata = 16'h0;
        error_cnt = 0;
        tests_run = 0;
        rows[0] = 24'h001500;
        rows[1] = 24'h052A03;
        rows[2] = 24'h1A5301;
        rows[3] = 24'h0FC300;
        rows[4] = 24'h040B03;
        rows[5] = 24'h1B7E02;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        #1 check({ser_out, ir_out_n, div_acc, rx_rdy, rdata[11:0]}, 16'hC000);
        repeat (2) @(posedge core_clk);
        rdr(`LFC_ADDR, d);
        check(d, 16'h0000);
        wrt(`LFC_ADDR, 16'hFFFF);
        rdr(`LFC_ADDR, d);
        check(d, 16'h00DF);
        check(div_acc, 1'b1);
        wrt(`DIV_LOW_ADDR, 16'h0001);
        wrt(`DIV_HIGH_ADDR, 16'h0000);
        rdr(`DIV_LOW_ADDR, d);
        check(d, 16'h0001);
        wrt(`LFC_ADDR, 16'h0003);
        rdr(`DIV_LOW_ADDR, d);
        check(d, 16'h0000);
        rdr(32'h50001040, d);
        check(d, 16'h0000);
        // Busy port: only the break bit may move
        busy <= 1'b1;
        wrt(`LFC_ADDR, 16'h00C4);
        rdr(`LFC_ADDR, d);
        check(d, 16'h0043);
        check(ser_out, 1'b0);
        busy <= 1'b0;
        ir_on <= 1'b1;
        repeat (20) @(posedge core_clk);
        n = 0;
        repeat (64) begin
            @(posedge core_clk);
            n = n + !ir_out_n;
        end
        check(n, 12);
        ir_on <= 1'b0;
        @(posedge core_clk);
        loop_on <= 1'b1;
        ir_on <= 1'b1;
        repeat (220) @(posedge core_clk);
        check({ser_out, ir_out_n}, 2'b10);
        rdr(`PORT_STATUS_ADDR, d);
        check(d & 16'h07FF, 16'h0500);
        wrt(`LFC_ADDR, 16'h0003);
        ir_on <= 1'b0;
        // Let the last break frame end, then clear its sticky framing flag
        repeat (170) @(posedge core_clk);
        rdr(`PORT_STATUS_ADDR, d);
        wrt(`TX_CHAR_ADDR, 16'h00A5);
        repeat (260) @(posedge core_clk);
        check(ser_out, 1'b1);
        rdr(`PORT_STATUS_ADDR, d);
        check(d & 16'h0FFF, 16'h01A5);
        loop_on <= 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            {lfc, ch, flt} = {rows[i][23:8], rows[i][1:0]};
            nb = 5 + lfc[1:0];
            wrt(`LFC_ADDR, {8'h00, lfc});
            t_fall = -1;
            fork
                rem_u.grab(bits);
                begin
                    wrt(`TX_CHAR_ADDR, {8'h00, ch});
                    k = 0;
                    d = 16'h0800;
                    while (d[11] && k < 300) begin
                        rdr(`PORT_STATUS_ADDR, d);
                        k = k + 1;
                    end
                    t1 = cyc;
                end
            join
            ebits = 12'hFFE;
            for (k = 0; k < nb; k = k + 1)
                ebits[k + 1] = ch[k];
            if (lfc[3])
                ebits[nb + 1] = ^(ch & ~(8'hFF << nb)) ^ !lfc[4];
            check(bits, ebits);
            exp = (1 + nb + lfc[3]) * 16 + (!lfc[2] ? 16 : nb == 5 ? 24 : 32);
            check(t1 - t_fall >= exp - 3 && t1 - t_fall <= exp + 4, 1'b1);
            rem_u.send(ch, nb, lfc[3], lfc[4], flt);
            if (flt == 2'd3)
                rem_u.send(ch, nb, lfc[3], lfc[4], 2'd0);
            check(rx_rdy, 1'b1);
            rdr(`PORT_STATUS_ADDR, d);
            check(d[10:0], {flt == 2'd2, flt == 2'd1, 1'b1, ch & ~(8'hFF << nb)});
            rdr(`PORT_STATUS_ADDR, d);
            check(d[8], 1'b0);
        end
        // Mid-run reset: outputs and fields must return to their reset values
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 check({ser_out, ir_out_n, div_acc, rx_rdy, rdata[11:0]}, 16'hC000);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdr(`LFC_ADDR, d);
        check(d, 16'h0000);
        conclude;
    end
endmodule
